// >>> include/backlight_pkg.sv
// Constants and types shared by the backlight dimming core
package backlight_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          SLOPE_MAX_MS   = 500;
    localparam int          SLOPE_CODES    = 15;
    localparam int          SLOPE_STEPS    = 4096;
    localparam int          SLOPE_UNIT_CYC = CLK_HZ / 1000 * SLOPE_MAX_MS
                                             / (SLOPE_CODES * SLOPE_STEPS);
    localparam logic [15:0] SLOPE_STEP     = 16'h0010;
    localparam int          ADAPT_US       = 50;
    localparam int          ADAPT_CYC      = CLK_HZ / 1_000_000 * ADAPT_US;

    ////////////////////////////////////////////////////////////////////////
    // Boost settings
    localparam logic [4:0] VB_MAX_CODE = 5'h1e;   // Codes above this give 40 V too
    localparam logic [7:0] VB_STEP_MAX = 8'hf0;   // 125 mV steps above 10 V
    localparam logic [7:0] SW_DIV_MIN  = 8'h10;   // Divider for the fastest rate

    ////////////////////////////////////////////////////////////////////////
    // Resolution selection
    localparam logic [3:0] RES_MIN      = 4'h8;
    localparam logic [4:0] CODE_MAX_10M = 5'h1b;
    localparam logic [4:0] CODE_MAX_20M = 5'h18;
    localparam logic [4:0] CODE_MAX_40M = 5'h08;
    // Resolution above minimum per resistor band, 3 bits each, per clock
    localparam logic [3:0][23:0] RES_BAND = {24'hb2_46db, 24'h8d_b492,
                                             24'h69_2449, 24'h44_9000};

    ////////////////////////////////////////////////////////////////////////
    // Configuration store
    localparam int          CFG_BYTES = 8;
    localparam logic [63:0] CFG_RESET = 64'h0000_0058_8fff_101f;

    typedef enum logic [1:0] {
        SRC_PIN     = 2'b00,
        SRC_PIN_ALT = 2'b01,
        SRC_REG     = 2'b10,
        SRC_DIRECT  = 2'b11
    } src_e;

    typedef struct packed {
        logic [23:0] spare_hi;
        logic [1:0]  input_undervoltage_threshold;
        logic        string_fault_threshold;
        logic        string_fault_enable;
        logic        adaptive_voltage_enable;
        logic [2:0]  headroom_threshold_code;
        logic        boost_auto_enable;
        logic [1:0]  switch_rate_code;
        logic [4:0]  boost_target_code;
        logic [7:0]  brightness_value;
        logic        spare_lo;
        logic [1:0]  brightness_source_select;
        logic        phase_shift_enable;
        logic [3:0]  slope_code;
        logic        freq_resistor_enable;
        logic [1:0]  gen_clock_res_code;
        logic [4:0]  out_freq_code;
    } cfg_s;

    typedef struct packed {
        logic [3:0] open_mask;
        logic [3:0] short_mask;
        logic [2:0] bad_count;
        logic       undervolt;
        logic       overcurrent;
        logic       thermal;
    } fault_s;

endpackage : backlight_pkg

// >>> verilog/backlight_pwm_dimming_control.sv
// Backlight PWM dimming, boost target and fault core
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Output PWM frequency comes from the 5-bit frequency code, scaled by multiplier
// - Two-bit code picks generation clock 5, 10, 20 or 40 MHz
// - Code and clock fix frequency and resolution; empty table cells are refused
// - Resistor-select bit takes frequency band from the external resistor instead
// - Phase shift delays each next output by a quarter PWM period
// - Without phase shift all four outputs switch on together
// - Four-bit slope code sets transition time 0 to 500 ms, both directions
// - Weakest headroom compared against threshold; boost target moves in 125 mV steps
// - String with highest forward voltage governs regulation, found automatically
// - Headroom threshold spans about 300 to 1200 mV; phase shift irrelevant
// - Configuration store is eight bytes of front end backed by nonvolatile copy
// - Front-end writes act at once; nonvolatile load and program are commands
// - Two-bit code selects boost switching from 156 kHz to 1.25 MHz
// - Boost auto-enable starts boost whenever backlight is enabled and no undervoltage, overcurrent or thermal shutdown holds
// - Adaptive start loads the manual voltage code, then adjusts from there
// - Manual target is 10 V plus 1 V per code; 30 and 31 give 40 V
// - Any LED, undervoltage, overcurrent or thermal fault pulls fault pin low
// - Fault read or enable pin low clears latched faults
// - String fault enable turns on continuous open and short monitoring
// - Faulty string leaves regulation; open, short and count are reported
// - One bit picks 3.3 V or 5.3 V allowed string variation
// - Source select: pin duty, brightness register, or pin passed straight through
// - Undervoltage stops outputs and boost, flags fault, restarts on recovery
module backlight_pwm_dimming_control #(
    parameter int ADAPT_CYC = backlight_pkg::ADAPT_CYC
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // Device pins
    input  wire logic              enable_pin,
    input  wire logic              pwm_in_pin,
    input  wire logic [2:0]        freq_resistor_pin,
    input  wire logic              fault_i,
    output logic                   fault_o,
    output logic                   fault_oe,
    // Analog monitor comparators, one bit per string for headroom, open and short
    input  wire logic [3:0]        headroom_low,
    input  wire logic [3:0]        headroom_high,
    input  wire logic [3:0]        string_open,
    input  wire logic [3:0]        string_short,
    input  wire logic              undervolt_det,
    input  wire logic              overcurrent_det,
    input  wire logic              thermal_det,
    // Control and configuration store
    input  wire logic              backlight_enable,
    input  wire logic              cfg_wr,
    input  wire logic [2:0]        cfg_addr,
    input  wire logic [7:0]        cfg_wdata,
    output logic      [7:0]        cfg_rdata,
    input  wire logic              nvm_load,
    input  wire logic              nvm_program,
    input  wire logic              fault_rd,
    output backlight_pkg::fault_s  fault_status,
    // Drivers and boost stage
    output logic      [3:0]        led_out,
    output logic                   boost_run,
    output logic                   boost_switch_tick,
    output logic      [7:0]        boost_target_step,
    output logic      [2:0]        headroom_ref,
    output logic                   fault_thr_sel,
    output logic      [1:0]        uv_ref_sel,
    output logic                   pwm_config_invalid
);

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for every pin except fault_i, and every comparator input
    logic [23:0] raw_in;
    logic [23:0] sync1_reg;
    logic [23:0] sync2_reg;
    logic        en_s;
    logic        pwm_s;
    logic [2:0]  band_s;
    logic [3:0]  hl_s;
    logic [3:0]  hh_s;
    logic [3:0]  op_s;
    logic [3:0]  sh_s;
    logic        uv_s;
    logic        oc_s;
    logic        tsd_s;

    assign raw_in = {enable_pin, pwm_in_pin, freq_resistor_pin, headroom_low, headroom_high,
                     string_open, string_short, undervolt_det, overcurrent_det, thermal_det};
    assign {en_s, pwm_s, band_s, hl_s, hh_s, op_s, sh_s, uv_s, oc_s, tsd_s} = sync2_reg;

    always_ff @(posedge clk_sys) begin
        sync1_reg <= sys_rst ? 24'h00_0000 : raw_in;
        sync2_reg <= sys_rst ? 24'h00_0000 : sync1_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration front end and its nonvolatile copy
    logic [7:0]          cfg_mem [backlight_pkg::CFG_BYTES];
    logic [7:0]          nvm_mem [backlight_pkg::CFG_BYTES];
    backlight_pkg::cfg_s cfg;

    assign cfg = {cfg_mem[7], cfg_mem[6], cfg_mem[5], cfg_mem[4],
                  cfg_mem[3], cfg_mem[2], cfg_mem[1], cfg_mem[0]};

    // front end written at once, copies only on command
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < backlight_pkg::CFG_BYTES; i++) begin
            if (sys_rst) begin
                cfg_mem[i] <= backlight_pkg::CFG_RESET[i*8 +: 8];
                nvm_mem[i] <= backlight_pkg::CFG_RESET[i*8 +: 8];
            end else begin
                if (nvm_load)
                    cfg_mem[i] <= nvm_mem[i];
                else if (cfg_wr && cfg_addr == 3'(i))
                    cfg_mem[i] <= cfg_wdata;
                if (nvm_program)
                    nvm_mem[i] <= cfg_mem[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Generation clock enable and resolution
    logic [1:0]  gdiv_reg;
    logic [1:0]  rc;
    logic        tick5;
    logic        gen_tick;
    logic [12:0] gen_step;
    logic [4:0]  code_lim;
    logic [2:0]  band_off;
    logic [3:0]  res;
    logic        cfg_ok;
    logic [12:0] mask;
    logic [12:0] quarter;

    // resolution follows the frequency code rows
    function automatic logic [3:0] code_res(input logic [4:0] c);
        logic [3:0] off;
        off = (c >= 5'h1c) ? 4'h0 : (c >= 5'h19) ? 4'h1 : (c >= 5'h09) ? 4'h2 :
              (c >= 5'h04) ? 4'h3 : (c >= 5'h01) ? 4'h4 : 4'h5;
        return backlight_pkg::RES_MIN + off;
    endfunction : code_res

    // 5 MHz base, doubled up to 40 MHz; 40 MHz counts two per cycle
    assign rc       = cfg.gen_clock_res_code;
    assign tick5    = gdiv_reg == 2'h3;
    assign gen_tick = (rc == 2'h0) ? tick5 : (rc == 2'h1) ? gdiv_reg[0] : 1'b1;
    assign gen_step = (rc == 2'h3) ? 13'h0002 : 13'h0001;
    // faster clocks leave the high codes unavailable
    assign code_lim = (rc == 2'h0) ? 5'h1f : (rc == 2'h1) ? backlight_pkg::CODE_MAX_10M :
                      (rc == 2'h2) ? backlight_pkg::CODE_MAX_20M : backlight_pkg::CODE_MAX_40M;
    // resistor band picks the row when selected
    assign band_off = backlight_pkg::RES_BAND[rc][band_s*3 +: 3];
    assign res      = cfg.freq_resistor_enable ? backlight_pkg::RES_MIN + {1'b0, band_off}
                                               : code_res(cfg.out_freq_code);
    assign cfg_ok   = cfg.freq_resistor_enable || cfg.out_freq_code <= code_lim;
    assign mask     = 13'((14'h0001 << res) - 14'h0001);
    assign quarter  = 13'(14'h0001 << (res - 4'h2));

    ////////////////////////////////////////////////////////////////////////
    // Input duty detector: high samples over a window of 8192 ticks at 5 MHz
    logic [12:0] win_reg;
    logic [12:0] hi_reg;
    logic [12:0] pin_duty_reg;
    logic        win_end;

    assign win_end = tick5 && win_reg == 13'h1fff;

    always_ff @(posedge clk_sys) begin
        gdiv_reg <= sys_rst ? 2'h0 : gdiv_reg + 2'h1;
        if (sys_rst) begin
            win_reg      <= 13'h0000;
            hi_reg       <= 13'h0000;
            pin_duty_reg <= 13'h0000;
        end else if (tick5) begin
            win_reg      <= win_reg + 13'h0001;
            hi_reg       <= win_end ? 13'h0000 : hi_reg + {12'h000, pwm_s};
            pin_duty_reg <= win_end ? hi_reg : pin_duty_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Duty source and sloper
    logic        direct;
    logic [15:0] target;
    logic [11:0] slc_reg;
    logic [11:0] slope_lim;
    logic [15:0] slope_reg;
    logic [15:0] slope_next;

    // source select, direct mode bypasses slope and phase
    assign direct = cfg.brightness_source_select == backlight_pkg::SRC_DIRECT;
    assign target = (cfg.brightness_source_select == backlight_pkg::SRC_REG)
                  ? {cfg.brightness_value, cfg.brightness_value}
                  : {pin_duty_reg, pin_duty_reg[12:10]};
    // same step rate up and down, full swing in code times about 33 ms
    assign slope_lim  = 12'(cfg.slope_code * backlight_pkg::SLOPE_UNIT_CYC);
    assign slope_next = (target > slope_reg)
        ? ((target - slope_reg > backlight_pkg::SLOPE_STEP)
           ? slope_reg + backlight_pkg::SLOPE_STEP : target)
        : ((slope_reg - target > backlight_pkg::SLOPE_STEP)
           ? slope_reg - backlight_pkg::SLOPE_STEP : target);

    always_ff @(posedge clk_sys) begin
        if (sys_rst || cfg.slope_code == 4'h0) begin
            slc_reg   <= 12'h000;
            slope_reg <= sys_rst ? 16'h0000 : target;
        end else if (slc_reg >= slope_lim - 12'h001) begin
            slc_reg   <= 12'h000;
            slope_reg <= slope_next;
        end else begin
            slc_reg   <= slc_reg + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM counter and per-output comparators
    logic [12:0] cnt_reg;
    logic [12:0] duty_res;
    logic [3:0]  lvl;

    // most significant bits of the sloped duty at the chosen resolution
    assign duty_res = 13'(slope_reg >> (5'h10 - {1'b0, res}));

    for (genvar i = 0; i < 4; i++) begin : g_out
        logic [12:0] ph;
        // quarter-period offsets only when phase shift is on
        assign ph     = cfg.phase_shift_enable ? 13'(quarter * i) : 13'h0000;
        assign lvl[i] = ((cnt_reg - ph) & mask) < duty_res;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            cnt_reg <= 13'h0000;
        else if (gen_tick)
            cnt_reg <= (cnt_reg + gen_step) & mask;
    end

    ////////////////////////////////////////////////////////////////////////
    // Run state, faults and boost control
    backlight_pkg::fault_s lat_reg;
    backlight_pkg::fault_s lat_next;
    logic        active;
    logic        uv_live;
    logic        shutdown;
    logic        drive_ok;
    logic        boost_on_next;
    logic        boost_start;
    logic        clr;
    logic [3:0]  str_mon;
    logic [3:0]  live;
    logic        need_up;
    logic        all_high;
    logic [4:0]  man_code;
    logic [7:0]  manual_step;
    logic [3:0]  led_reg;
    logic        boost_run_reg;
    logic        sw_tick_reg;
    logic [7:0]  sw_cnt_reg;
    logic [7:0]  sw_term;
    logic [15:0] ad_cnt_reg;
    logic        ad_tick;
    logic [7:0]  tgt_reg;
    logic        fault_oe_reg;
    logic [7:0]  rdata_reg;
    logic [6:0]  misc_reg;

    // undervolt stops drive while present, threshold code zero disables it
    assign active        = en_s && backlight_enable;
    assign uv_live       = uv_s && cfg.input_undervoltage_threshold != 2'h0;
    assign shutdown      = uv_live || lat_reg.overcurrent || tsd_s;
    assign drive_ok      = active && !shutdown && cfg_ok;
    // boost follows backlight enable when auto-enable is set
    assign boost_on_next = active && !shutdown && cfg.boost_auto_enable;
    assign boost_start   = boost_on_next && !boost_run_reg;
    // read strobe or enable pin low clears
    assign clr           = fault_rd || !en_s;
    assign str_mon       = {4{cfg.string_fault_enable && active}};

    // set wins over clear; count of faulty strings
    always_comb begin
        lat_next.open_mask   = (str_mon & op_s) | (clr ? 4'h0 : lat_reg.open_mask);
        lat_next.short_mask  = (str_mon & sh_s) | (clr ? 4'h0 : lat_reg.short_mask);
        lat_next.undervolt   = uv_live || (!clr && lat_reg.undervolt);
        lat_next.overcurrent = oc_s || (!clr && lat_reg.overcurrent);
        lat_next.thermal     = tsd_s || (!clr && lat_reg.thermal);
        lat_next.bad_count   = 3'h0;
        for (int i = 0; i < 4; i++)
            lat_next.bad_count = lat_next.bad_count
                + {2'h0, lat_next.open_mask[i] | lat_next.short_mask[i]};
    end

    // faulty strings leave the loop, weakest live string governs
    assign live     = ~(lat_reg.open_mask | lat_reg.short_mask);
    assign need_up  = |(hl_s & live);
    assign all_high = &(hh_s | ~live);
    // one volt is eight 125 mV steps, top codes clamp
    assign man_code    = (cfg.boost_target_code > backlight_pkg::VB_MAX_CODE)
                       ? backlight_pkg::VB_MAX_CODE : cfg.boost_target_code;
    assign manual_step = {man_code, 3'h0};
    // divide by 128, 64, 32 or 16
    assign sw_term = (backlight_pkg::SW_DIV_MIN << (2'h3 - cfg.switch_rate_code)) - 8'h01;
    assign ad_tick = ad_cnt_reg == 16'(ADAPT_CYC - 1);

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !boost_run_reg) begin
            sw_cnt_reg  <= 8'h00;
            sw_tick_reg <= 1'b0;
        end else begin
            sw_cnt_reg  <= (sw_cnt_reg >= sw_term) ? 8'h00 : sw_cnt_reg + 8'h01;
            sw_tick_reg <= sw_cnt_reg >= sw_term;
        end
    end

    // adaptive start from manual code, then single 125 mV steps
    always_ff @(posedge clk_sys) begin
        ad_cnt_reg <= (sys_rst || ad_tick) ? 16'h0000 : ad_cnt_reg + 16'h0001;
        if (sys_rst)
            tgt_reg <= 8'h00;
        else if (!cfg.adaptive_voltage_enable || boost_start)
            tgt_reg <= manual_step;
        else if (boost_run_reg && ad_tick && need_up && tgt_reg < backlight_pkg::VB_STEP_MAX)
            tgt_reg <= tgt_reg + 8'h01;
        else if (boost_run_reg && ad_tick && !need_up && all_high && tgt_reg != 8'h00)
            tgt_reg <= tgt_reg - 8'h01;
    end

    // Output registers; analog references follow the store one cycle late
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lat_reg       <= '0;
            led_reg       <= 4'h0;
            boost_run_reg <= 1'b0;
            fault_oe_reg  <= 1'b0;
            rdata_reg     <= 8'h00;
            misc_reg      <= 7'h00;
        end else begin
            lat_reg       <= lat_next;
            led_reg       <= !drive_ok ? 4'h0 : direct ? {4{pwm_s}} : lvl;
            boost_run_reg <= boost_on_next;
            // pin held low while anything stays latched
            fault_oe_reg  <= |{lat_next.open_mask, lat_next.short_mask, lat_next.undervolt,
                               lat_next.overcurrent, lat_next.thermal};
            rdata_reg     <= cfg_mem[cfg_addr];
            // threshold codes go to comparators, same in both PWM schemes
            misc_reg      <= {!cfg_ok, cfg.input_undervoltage_threshold,
                              cfg.string_fault_threshold, cfg.headroom_threshold_code};
        end
    end

    assign fault_o            = 1'b0;   // Open drain: only the enable moves
    assign fault_oe           = fault_oe_reg;
    assign fault_status       = lat_reg;
    assign cfg_rdata          = rdata_reg;
    assign led_out            = led_reg;
    assign boost_run          = boost_run_reg;
    assign boost_switch_tick  = sw_tick_reg;
    assign boost_target_step  = tgt_reg;
    assign headroom_ref       = misc_reg[2:0];
    assign fault_thr_sel      = misc_reg[3];
    assign uv_ref_sel         = misc_reg[5:4];
    assign pwm_config_invalid = misc_reg[6];

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_read_clears: assert property (fault_rd && en_s && lat_next == '0 |=> !fault_oe)
        else $error("fault pin held after read clear");
    a_event_latches: assert property (oc_s |=> fault_oe && fault_status.overcurrent)
        else $error("overcurrent did not latch");
    a_fault_hold: assert property (fault_oe && !clr && !fault_rd |=> fault_oe)
        else $error("fault pin released while latched");
    a_uv_stop: assert property (uv_live |=> led_out == 4'h0 && !boost_run)
        else $error("drive active during undervoltage");
    a_no_shift: assert property (!cfg.phase_shift_enable && !direct
                                 |=> led_out == 4'h0 || led_out == 4'hf)
        else $error("outputs differ without phase shift");
    a_manual_tgt: assert property (!cfg.adaptive_voltage_enable
                                   |=> boost_target_step == $past(manual_step))
        else $error("manual target mismatch");
    a_adapt_step: assert property (cfg.adaptive_voltage_enable && !boost_start
        |=> boost_target_step == $past(tgt_reg) || boost_target_step == $past(tgt_reg) + 8'h01
            || boost_target_step == $past(tgt_reg) - 8'h01)
        else $error("adaptive step larger than one");
    a_cnt_wrap: assert property (gen_tick && $stable(mask) |=> cnt_reg <= $past(mask))
        else $error("counter beyond period");
    a_slope_zero: assert property (cfg.slope_code == 4'h0 |=> slope_reg == $past(target))
        else $error("zero slope not immediate");
    a_direct_pass: assert property (direct && drive_ok |=> led_out == {4{$past(pwm_s)}})
        else $error("direct mode not following pin");

    c_fault_seen: cover property ($rose(fault_oe));
    c_adapt_up: cover property (boost_run && boost_target_step == $past(tgt_reg) + 8'h01);
    c_shifted: cover property (cfg.phase_shift_enable && led_out == 4'h1);

endmodule : backlight_pwm_dimming_control

`default_nettype wire

// >>> test/backlight_stage_model.sv
// Boost stage and LED string stand-in for the dimming core
`timescale 1ns/1ps
`default_nettype none
module backlight_stage_model #(
    parameter logic [7:0] NEED = 8'h40  // Plain default demand of the worst string
) (
    // Boost command and fault line
    input  wire logic [7:0] target,
    input  wire logic       fault_oe,
    output logic            fault_pin,
    // Comparators
    input  wire logic [2:0] inject,
    output logic      [3:0] hr_low,
    output logic      [3:0] hr_high,
    output logic      [2:0] det
);
    // worst string governs
    // String 0 needs the most voltage, so only it can report low headroom
    assign hr_low = {3'b000, target < NEED};
    assign hr_high = {3'b111, target > NEED + 8'h04};
    // Pull-up holds the line high unless the core sinks it
    assign fault_pin = fault_oe ? 1'b0 : 1'b1;
    // Undervoltage, overcurrent, thermal on command
    assign det = inject;
endmodule : backlight_stage_model
`default_nettype wire

// >>> test/backlight_pwm_dimming_control_tb.sv
// Self-checking bench for the backlight dimming core
`timescale 1ns/1ps
`default_nettype none
module backlight_pwm_dimming_control_tb;
    logic clk_sys = 0, sys_rst = 1, enable_pin = 1, backlight_enable = 1, cfg_wr = 0, pwm_in = 0;
    logic nvm_load = 0, fault_rd = 0, fault_oe, fault_pin, boost_run, pwm_config_invalid;
    logic [2:0] cfg_addr = 0, inject = 0, det;
    logic [7:0] cfg_wdata = 0, cfg_rdata, boost_target_step;
    logic [3:0] led_out, hr_low, hr_high, open_s = 0;
    backlight_pkg::fault_s fault_status;
    int fails = 0, comparisons = 0;
    initial forever #25 clk_sys = ~clk_sys;
    backlight_pwm_dimming_control #(.ADAPT_CYC(8)) i_backlight_pwm_dimming_control (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .enable_pin(enable_pin), .pwm_in_pin(pwm_in),
        .freq_resistor_pin(3'h7), .fault_i(fault_pin), .fault_o(), .fault_oe(fault_oe),
        .headroom_low(hr_low), .headroom_high(hr_high), .string_open(open_s),
        .string_short(4'h0), .undervolt_det(det[2]), .overcurrent_det(det[1]),
        .thermal_det(det[0]), .backlight_enable(backlight_enable), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .nvm_load(nvm_load), .nvm_program(1'b0), .fault_rd(fault_rd),
        .fault_status(fault_status), .led_out(led_out), .boost_run(boost_run),
        .boost_switch_tick(), .boost_target_step(boost_target_step), .headroom_ref(),
        .fault_thr_sel(), .uv_ref_sel(), .pwm_config_invalid(pwm_config_invalid));
    backlight_stage_model i_backlight_stage_model (.target(boost_target_step),
        .fault_oe(fault_oe), .fault_pin(fault_pin), .inject(inject), .hr_low(hr_low),
        .hr_high(hr_high), .det(det));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(negedge clk_sys) cfg_wr = 0;
        repeat (3) @(negedge clk_sys);
    endtask : wr
    task automatic t_store;
        cfg_addr = 3'h4;
        repeat (2) @(negedge clk_sys);
        check(cfg_rdata, backlight_pkg::CFG_RESET[39:32]);
        wr(3'h2, 8'h5a);
        check(cfg_rdata, 8'h5a);
        @(negedge clk_sys) nvm_load = 1;
        @(negedge clk_sys) nvm_load = 0;
        repeat (2) @(negedge clk_sys);
        check(cfg_rdata, backlight_pkg::CFG_RESET[23:16]);
        $display("store test done");
    endtask : t_store
    task automatic t_boost;
        logic [4:0] c;
        wr(3'h4, 8'h50);
        for (int i = 0; i < 5; i++) begin
            c = (i < 4) ? 5'(i * 10) : 5'h1f;
            wr(3'h3, {3'b100, c});
            check(boost_target_step, 8'((c > 5'h1e ? 5'h1e : c) * 8));
            check(boost_run, 1'b1);
        end
        $display("boost test done");
    endtask : t_boost
    task automatic t_pwm;
        int hi, bad, n;
        {hi, bad, n} = 0;
        wr(3'h0, 8'h1f);
        wr(3'h2, 8'h80);
        wr(3'h1, 8'h40);
        repeat (2100) @(negedge clk_sys);
        repeat (1024) @(negedge clk_sys) begin
            hi += led_out[0];
            bad += (led_out !== 4'h0 && led_out !== 4'hf);
        end
        check(16'(bad), 0);
        check(16'(hi), 512);
        wr(3'h1, 8'h50);
        repeat (2100) @(negedge clk_sys);
        // Sample only at falling edges so the count starts half a cycle after the rise
        while (led_out[0] !== 1'b0) @(negedge clk_sys);
        while (led_out[0] !== 1'b1) @(negedge clk_sys);
        while (led_out[1] !== 1'b1 && n < 2000) @(negedge clk_sys) n++;
        check(16'(n), 256);
        wr(3'h1, 8'h60);
        pwm_in = 1;
        repeat (4) @(negedge clk_sys);
        check(led_out, 4'hf);
        pwm_in = 0;
        repeat (4) @(negedge clk_sys);
        check(led_out, 4'h0);
        wr(3'h0, 8'h7f);
        check(pwm_config_invalid, 1'b1);
        repeat (1100) @(negedge clk_sys) bad += (led_out !== 4'h0);
        check(16'(bad), 0);
        $display("pwm test done");
    endtask : t_pwm
    task automatic t_fault;
        for (int i = 0; i < 3; i++) begin
            inject = 3'b001 << i;
            repeat (5) @(negedge clk_sys);
            inject = 0;
            repeat (5) @(negedge clk_sys);
            check(fault_status[2:0], 3'b001 << i);
            check(fault_pin, 1'b0);
            @(negedge clk_sys) fault_rd = 1;
            @(negedge clk_sys) fault_rd = 0;
            check({fault_status, fault_oe}, 0);
        end
        open_s = 4'h4;
        repeat (5) @(negedge clk_sys) open_s = 0;
        check({fault_status, fault_oe}, {4'h4, 4'h0, 3'h1, 3'h0, 1'b1});
        inject = 3'b010;
        repeat (5) @(negedge clk_sys) inject = 0;
        enable_pin = 0;
        repeat (5) @(negedge clk_sys);
        check({fault_status, fault_oe}, 0);
        enable_pin = 1;
        $display("fault test done");
    endtask : t_fault
    task automatic t_adapt;
        wr(3'h4, 8'h58);
        // Settles at the top of the model's dead band
        repeat (2000) @(negedge clk_sys);
        check(boost_target_step, 8'h44);
        backlight_enable = 0;
        @(negedge clk_sys) backlight_enable = 1;
        @(negedge clk_sys);
        check(boost_target_step, 8'hf0);
        $display("adapt test done");
    endtask : t_adapt
    initial begin
        repeat (16) @(negedge clk_sys);
        sys_rst = 0;
        repeat (4) @(negedge clk_sys);
        t_store();
        t_boost();
        t_pwm();
        t_fault();
        t_adapt();
        final_report();
    end
    // Watchdog, well beyond the roughly ten thousand cycles the tests need
    initial begin
        #1_500_000;
        fails++;
        final_report();
    end
endmodule : backlight_pwm_dimming_control_tb
`default_nettype wire
